// [logic/ate_pkg.sv]
// shared constants and types for the task-file write command executor
package ate_pkg;
  // task-file register addresses
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERR = 3'h1;
  localparam logic [2:0] REG_CNT = 3'h2;
  localparam logic [2:0] REG_SEC = 3'h3;
  localparam logic [2:0] REG_CYL_LO = 3'h4;
  localparam logic [2:0] REG_CYL_HI = 3'h5;
  localparam logic [2:0] REG_DH = 3'h6;
  localparam logic [2:0] REG_CMD = 3'h7;
  // opcodes
  localparam logic [7:0] OP_STBY_A = 8'hE0;
  localparam logic [7:0] OP_STBY_B = 8'h94;
  localparam logic [7:0] OP_TRANSLATE = 8'h87;
  localparam logic [7:0] OP_WR_BUF = 8'hE8;
  localparam logic [7:0] OP_WR_DMA_A = 8'hCA;
  localparam logic [7:0] OP_WR_DMA_B = 8'hCB;
  localparam logic [7:0] OP_WR_MULT = 8'hC5;
  localparam logic [7:0] OP_WR_MULT_NE = 8'hCD;
  localparam logic [7:0] OP_WR_SEC_A = 8'h30;
  localparam logic [7:0] OP_WR_SEC_B = 8'h31;
  localparam logic [7:0] OP_WR_SEC_NE = 8'h38;
  localparam logic [7:0] OP_SET_MULT = 8'hC6;
  // status, error and drive/head bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ICRC = 7;
  localparam int ER_ABRT = 2;
  localparam int DH_LBA = 6;
  // sector and translation buffer layout
  localparam logic [8:0] LAST_BYTE = 9'h1FF;
  localparam logic [8:0] SECTORS_ZERO_CNT = 9'h100;
  localparam logic [8:0] TB_CYL_MSB = 9'h000;
  localparam logic [8:0] TB_CYL_LSB = 9'h001;
  localparam logic [8:0] TB_HEAD = 9'h002;
  localparam logic [8:0] TB_SEC = 9'h003;
  localparam logic [8:0] TB_LBA_MSB = 9'h004;
  localparam logic [8:0] TB_LBA_MID = 9'h005;
  localparam logic [8:0] TB_LBA_LSB = 9'h006;
  localparam logic [8:0] TB_ERASED = 9'h013;
  localparam logic [8:0] TB_HOT_MSB = 9'h018;
  localparam logic [8:0] TB_HOT_MID = 9'h019;
  localparam logic [8:0] TB_HOT_LSB = 9'h01A;
  localparam logic [7:0] TB_ERASED_VAL = 8'hFF;
  localparam logic [7:0] TB_NOT_ERASED = 8'h00;
  localparam logic [7:0] TB_RSVD = 8'h00;
  localparam logic [7:0] MAX_BLOCK = 8'h01;
  // CHS geometry
  localparam logic [27:0] CHS_HEADS = 28'h0000010;
  localparam logic [27:0] CHS_SPT = 28'h000003F;
  // values after reset
  localparam logic [7:0] RST_ERR = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h01;
  localparam logic [7:0] RST_SEC = 8'h01;
  localparam logic [7:0] RST_DH = 8'hA0;
  // busy deadline after a command write
  localparam int CLK_NS = 4;
  localparam int BSY_LIMIT_NS = 400;
  localparam int BSY_LIMIT_CYC = BSY_LIMIT_NS / CLK_NS;
  typedef enum logic [2:0] {S_IDLE, S_BUSY, S_XFER, S_PROG, S_FILL, S_OUT} ate_state_type;
endpackage

// [logic/ate_sector_buf.sv]
// 512-byte sector buffer, one write port and one registered read port
`timescale 1ns/100ps
`default_nettype none
module ate_sector_buf (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic we_in,
  input wire logic [8:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [8:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:511];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule
`default_nettype wire

// [logic/ate_addr_calc.sv]
// address decode of the task-file fields and next-sector stepping
`timescale 1ns/100ps
`default_nettype none
module ate_addr_calc (
  input wire logic [7:0] dh_in,
  input wire logic [7:0] cyl_hi_in,
  input wire logic [7:0] cyl_lo_in,
  input wire logic [7:0] sec_in,
  output logic [27:0] lba_out,
  output logic [7:0] dh_out,
  output logic [7:0] cyl_hi_out,
  output logic [7:0] cyl_lo_out,
  output logic [7:0] sec_out
);
  logic [27:0] lba_nx;
  logic [15:0] cyl_nx;

  always_comb begin
    lba_nx = 28'h0000000;
    cyl_nx = {cyl_hi_in, cyl_lo_in};
    dh_out = dh_in;
    sec_out = sec_in;
    if (dh_in[ate_pkg::DH_LBA]) begin
      // head nibble, cylinder high, cylinder low, sector number
      lba_out = {dh_in[3:0], cyl_hi_in, cyl_lo_in, sec_in};
      lba_nx = lba_out + 28'h0000001;
      dh_out = {dh_in[7:4], lba_nx[27:24]};
      cyl_nx = lba_nx[23:8];
      sec_out = lba_nx[7:0];
    end else begin
      lba_out = ((28'({cyl_hi_in, cyl_lo_in}) * ate_pkg::CHS_HEADS + 28'(dh_in[3:0])) * ate_pkg::CHS_SPT)
        + 28'(sec_in) - 28'h0000001;
      if (28'(sec_in) < ate_pkg::CHS_SPT) begin
        sec_out = sec_in + 8'h01;
      end else begin
        sec_out = 8'h01;
        if (28'(dh_in[3:0]) < ate_pkg::CHS_HEADS - 28'h0000001) begin
          dh_out = {dh_in[7:4], dh_in[3:0] + 4'h1};
        end else begin
          dh_out = {dh_in[7:4], 4'h0};
          cyl_nx = cyl_nx + 16'h0001;
        end
      end
    end
    cyl_hi_out = cyl_nx[15:8];
    cyl_lo_out = cyl_nx[7:0];
  end
endmodule
`default_nettype wire

// [logic/ate_write_exec.sv]
// task-file write command executor: standby, translate, buffer, PIO, multiple and DMA writes
`timescale 1ns/100ps
`default_nettype none
module ate_write_exec (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic intrq_out,
  output logic sleep_out,
  output logic dmarq_out,
  input wire logic dmack_in,
  input wire logic [7:0] dma_data_in,
  input wire logic udma_mode_in,
  input wire logic udma_crc_err_in,
  output logic media_req_out,
  output logic [27:0] media_lba_out,
  output logic media_noerase_out,
  input wire logic media_done_in,
  input wire logic media_err_in,
  input wire logic media_erased_in,
  input wire logic [23:0] media_hot_in,
  input wire logic [8:0] media_addr_in,
  output logic [7:0] media_data_out
);
  typedef struct packed {
    ate_pkg::ate_state_type st;
    logic [7:0] err;
    logic [7:0] cnt;
    logic [7:0] sec;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dh;
    logic [7:0] cmd;
    logic bsy;
    logic drq;
    logic errb;
    logic irq;
    logic sleep;
    logic mult_en;
    logic dma;
    logic first;
    logic crc;
    logic ne;
    logic skip;
    logic bufonly;
    logic rsel;
    logic [8:0] rem;
    logic [8:0] idx;
    logic [7:0] rdata;
    logic [27:0] lba;
  } ate_regs_type;

  ate_regs_type s;
  ate_regs_type next_s;
  logic [27:0] lba_cur;
  logic [7:0] nx_dh, nx_cyl_hi, nx_cyl_lo, nx_sec;
  logic bwe;
  logic [8:0] bwaddr, braddr;
  logic [7:0] bwdata, buf_q, stat;
  logic take, done_ok, do_abort, cmd_wr;

  function automatic logic [7:0] trans_byte(input logic [8:0] i, input logic [7:0] ch, input logic [7:0] cl,
                                            input logic [7:0] hd, input logic [7:0] sc, input logic [27:0] lba,
                                            input logic erased, input logic [23:0] hot);
    logic [7:0] b;
    b = ate_pkg::TB_RSVD; // reserved ranges filled
    case (i)
      ate_pkg::TB_CYL_MSB: b = ch;
      ate_pkg::TB_CYL_LSB: b = cl;
      ate_pkg::TB_HEAD: b = {4'h0, hd[3:0]};
      ate_pkg::TB_SEC: b = sc;
      ate_pkg::TB_LBA_MSB: b = lba[23:16];
      ate_pkg::TB_LBA_MID: b = lba[15:8];
      ate_pkg::TB_LBA_LSB: b = lba[7:0];
      ate_pkg::TB_ERASED: b = erased ? ate_pkg::TB_ERASED_VAL : ate_pkg::TB_NOT_ERASED;
      ate_pkg::TB_HOT_MSB: b = hot[23:16]; // zero count from media means unsupported
      ate_pkg::TB_HOT_MID: b = hot[15:8];
      ate_pkg::TB_HOT_LSB: b = hot[7:0];
      default: b = ate_pkg::TB_RSVD;
    endcase
    return b;
  endfunction

  ate_addr_calc u_addr (
    .dh_in(s.dh),
    .cyl_hi_in(s.cyl_hi),
    .cyl_lo_in(s.cyl_lo),
    .sec_in(s.sec),
    .lba_out(lba_cur),
    .dh_out(nx_dh),
    .cyl_hi_out(nx_cyl_hi),
    .cyl_lo_out(nx_cyl_lo),
    .sec_out(nx_sec)
  );

  ate_sector_buf u_buf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .we_in(bwe),
    .waddr_in(bwaddr),
    .wdata_in(bwdata),
    .raddr_in(braddr),
    .rdata_out(buf_q)
  );

  assign cmd_wr = wr_in && (addr_in == ate_pkg::REG_CMD) && (s.st == ate_pkg::S_IDLE);

  always_comb begin
    stat = 8'h00;
    stat[ate_pkg::ST_BSY] = s.bsy;
    stat[ate_pkg::ST_DRDY] = ~s.bsy;
    stat[ate_pkg::ST_DSC] = 1'b1;
    stat[ate_pkg::ST_DRQ] = s.drq;
    stat[ate_pkg::ST_ERR] = s.errb;
  end

  always_comb begin
    next_s = s;
    bwe = 1'b0;
    bwaddr = s.idx;
    bwdata = 8'h00;
    braddr = s.idx;
    take = 1'b0;
    done_ok = 1'b0;
    do_abort = 1'b0;
    next_s.rsel = 1'b0;
    if (rd_in) begin
      next_s.rsel = (addr_in == ate_pkg::REG_DATA);
      case (addr_in)
        ate_pkg::REG_ERR: next_s.rdata = s.err;
        ate_pkg::REG_CNT: next_s.rdata = s.cnt;
        ate_pkg::REG_SEC: next_s.rdata = s.sec;
        ate_pkg::REG_CYL_LO: next_s.rdata = s.cyl_lo;
        ate_pkg::REG_CYL_HI: next_s.rdata = s.cyl_hi;
        ate_pkg::REG_DH: next_s.rdata = s.dh;
        ate_pkg::REG_CMD: begin
          next_s.rdata = stat;
          next_s.irq = 1'b0;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
    case (s.st)
      ate_pkg::S_IDLE: begin
        if (cmd_wr) begin
          next_s.cmd = wdata_in;
          next_s.st = ate_pkg::S_BUSY;
          next_s.bsy = 1'b1;
          next_s.sleep = 1'b0;
          next_s.irq = 1'b0;
          next_s.err = 8'h00;
          next_s.errb = 1'b0;
          next_s.crc = 1'b0;
          next_s.dma = 1'b0;
          next_s.bufonly = 1'b0;
          next_s.ne = 1'b0;
          next_s.rem = (s.cnt == 8'h00) ? ate_pkg::SECTORS_ZERO_CNT : {1'b0, s.cnt};
        end else if (wr_in) begin
          case (addr_in)
            ate_pkg::REG_CNT: next_s.cnt = wdata_in;
            ate_pkg::REG_SEC: next_s.sec = wdata_in;
            ate_pkg::REG_CYL_LO: next_s.cyl_lo = wdata_in;
            ate_pkg::REG_CYL_HI: next_s.cyl_hi = wdata_in;
            ate_pkg::REG_DH: next_s.dh = wdata_in;
            default: next_s.cnt = s.cnt;
          endcase
        end
      end
      ate_pkg::S_BUSY: begin
        next_s.idx = 9'h000;
        next_s.first = 1'b1;
        next_s.st = ate_pkg::S_XFER;
        next_s.bsy = 1'b0;
        next_s.drq = 1'b1; // data request with busy released, no interrupt
        case (s.cmd)
          ate_pkg::OP_STBY_A, ate_pkg::OP_STBY_B: begin
            next_s.sleep = 1'b1;
            done_ok = 1'b1;
          end
          ate_pkg::OP_SET_MULT: begin
            next_s.mult_en = (s.cnt != 8'h00) && (s.cnt <= ate_pkg::MAX_BLOCK);
            do_abort = (s.cnt > ate_pkg::MAX_BLOCK);
            done_ok = 1'b1;
          end
          ate_pkg::OP_TRANSLATE: begin
            next_s.st = ate_pkg::S_FILL;
            next_s.drq = 1'b0;
            next_s.bsy = 1'b1;
            next_s.first = 1'b0;
          end
          ate_pkg::OP_WR_BUF: next_s.bufonly = 1'b1;
          ate_pkg::OP_WR_SEC_A, ate_pkg::OP_WR_SEC_B: next_s.ne = 1'b0;
          ate_pkg::OP_WR_SEC_NE: next_s.ne = 1'b1;
          ate_pkg::OP_WR_MULT, ate_pkg::OP_WR_MULT_NE: begin
            next_s.ne = (s.cmd == ate_pkg::OP_WR_MULT_NE);
            do_abort = ~s.mult_en;
          end
          ate_pkg::OP_WR_DMA_A, ate_pkg::OP_WR_DMA_B: next_s.dma = 1'b1;
          default: do_abort = 1'b1;
        endcase
      end
      ate_pkg::S_XFER: begin
        take = s.dma ? dmack_in : (wr_in && (addr_in == ate_pkg::REG_DATA));
        if (s.dma && udma_mode_in && udma_crc_err_in) begin
          next_s.crc = 1'b1;
        end
        if (take) begin
          bwe = 1'b1;
          bwdata = s.dma ? dma_data_in : wdata_in;
          next_s.idx = s.idx + 9'h001;
          if (s.idx == ate_pkg::LAST_BYTE) begin
            next_s.drq = 1'b0;
            next_s.bsy = 1'b1;
            next_s.lba = lba_cur;
            next_s.skip = s.ne && media_erased_in;
            if (s.bufonly) begin
              done_ok = 1'b1;
            end else begin
              next_s.st = ate_pkg::S_PROG;
            end
          end
        end
      end
      ate_pkg::S_PROG: begin
        braddr = media_addr_in;
        if (media_done_in) begin
          if (media_err_in) begin
            next_s.cnt = s.rem[7:0]; // failing address kept, residual count
            do_abort = 1'b1;
          end else begin
            next_s.rem = s.rem - 9'h001;
            next_s.cnt = next_s.rem[7:0];
            if (s.rem == 9'h001) begin
              done_ok = 1'b1; // address left on last sector
            end else begin
              // block of one sector: each sector is its own block
              next_s.dh = nx_dh;
              next_s.cyl_hi = nx_cyl_hi;
              next_s.cyl_lo = nx_cyl_lo;
              next_s.sec = nx_sec;
              next_s.st = ate_pkg::S_XFER;
              next_s.idx = 9'h000;
              next_s.first = 1'b0;
              next_s.bsy = 1'b0;
              next_s.drq = 1'b1;
              next_s.irq = ~s.dma;
            end
          end
        end
      end
      ate_pkg::S_FILL: begin
        bwe = 1'b1;
        bwdata = trans_byte(s.idx, s.cyl_hi, s.cyl_lo, s.dh, s.sec, lba_cur, media_erased_in,
                            media_hot_in);
        next_s.idx = s.idx + 9'h001;
        if (s.idx == ate_pkg::LAST_BYTE) begin
          next_s.st = ate_pkg::S_OUT;
          next_s.bsy = 1'b0;
          next_s.drq = 1'b1;
          next_s.irq = 1'b1;
        end
      end
      ate_pkg::S_OUT: begin
        if (rd_in && (addr_in == ate_pkg::REG_DATA)) begin
          next_s.idx = s.idx + 9'h001;
          done_ok = (s.idx == ate_pkg::LAST_BYTE);
        end
      end
      default: next_s.st = ate_pkg::S_IDLE;
    endcase
    if (done_ok || do_abort) begin
      next_s.st = ate_pkg::S_IDLE;
      next_s.bsy = 1'b0;
      next_s.drq = 1'b0;
      next_s.irq = 1'b1; // completion interrupt
      if (do_abort) begin
        next_s.errb = 1'b1;
        next_s.err[ate_pkg::ER_ABRT] = 1'b1;
      end
      if (next_s.crc) begin
        next_s.errb = 1'b1;
        next_s.err[ate_pkg::ER_ICRC] = 1'b1;
        next_s.err[ate_pkg::ER_ABRT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0; // multiple mode disabled
      s.err <= ate_pkg::RST_ERR;
      s.cnt <= ate_pkg::RST_CNT;
      s.sec <= ate_pkg::RST_SEC;
      s.dh <= ate_pkg::RST_DH;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rsel ? buf_q : s.rdata;
  assign intrq_out = s.irq;
  assign sleep_out = s.sleep;
  assign dmarq_out = s.dma && (s.st == ate_pkg::S_XFER);
  assign media_req_out = (s.st == ate_pkg::S_PROG);
  assign media_lba_out = s.lba;
  assign media_noerase_out = s.skip;
  assign media_data_out = buf_q;

  localparam int BSY_WIN = ate_pkg::BSY_LIMIT_CYC;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_STBY_SLEEP: assert property (cmd_wr && (wdata_in == ate_pkg::OP_STBY_A || wdata_in == ate_pkg::OP_STBY_B)
    |=> s.bsy ##1 (sleep_out && intrq_out && !s.bsy)) else $error("standby did not sleep and interrupt");
  AST_WAKE: assert property (sleep_out && cmd_wr |=> !sleep_out) else $error("command did not wake");
  AST_BSY_400: assert property (cmd_wr && wdata_in == ate_pkg::OP_WR_MULT |-> ##[1:BSY_WIN] s.bsy)
    else $error("busy late after multiple write");
  AST_CNT256: assert property (cmd_wr && wdata_in == ate_pkg::OP_WR_SEC_A && s.cnt == 8'h00
    |=> s.rem == 9'h100) else $error("zero count not 256");
  AST_FIRST_DRQ: assert property (s.drq && s.first |-> !intrq_out && !s.bsy)
    else $error("interrupt on first data request");
  AST_MULT_ABORT: assert property (cmd_wr && wdata_in == ate_pkg::OP_WR_MULT && !s.mult_en
    |-> ##2 (s.err[ate_pkg::ER_ABRT] && !s.bsy && intrq_out)) else $error("multiple write not aborted");
  AST_DMA_IRQ: assert property (s.dma && s.st != ate_pkg::S_IDLE |-> !intrq_out && (s.bsy || s.drq))
    else $error("dma interrupt before end");
  AST_CRC: assert property (s.crc && s.st != ate_pkg::S_IDLE ##1 s.st == ate_pkg::S_IDLE
    |-> s.err[ate_pkg::ER_ICRC] && s.err[ate_pkg::ER_ABRT]) else $error("crc error bits missing");
  AST_ERR_STOP: assert property (s.st == ate_pkg::S_PROG && media_done_in && media_err_in
    |=> s.st == ate_pkg::S_IDLE && s.cnt == $past(s.rem[7:0]) && $stable(s.sec)) else $error("error did not stop");
  AST_LAST_ADDR: assert property (s.st == ate_pkg::S_PROG && media_done_in && !media_err_in && s.rem == 9'h001
    |=> s.st == ate_pkg::S_IDLE && $stable(s.sec) && intrq_out) else $error("last address moved");

  COV_STBY: cover property (cmd_wr && wdata_in == ate_pkg::OP_STBY_A ##2 sleep_out);
  COV_DMA_DONE: cover property (s.dma && s.st == ate_pkg::S_PROG ##1 s.st == ate_pkg::S_IDLE);
  COV_TRANS_DONE: cover property (s.st == ate_pkg::S_OUT ##1 s.st == ate_pkg::S_IDLE);
  COV_MULT_ABORT: cover property (s.st == ate_pkg::S_BUSY && s.cmd == ate_pkg::OP_WR_MULT && !s.mult_en);
endmodule
`default_nettype wire

// [verif/ate_media_model.sv]
// flash media stand-in: answers program requests after a fixed delay
`timescale 1ns/100ps
`default_nettype none
module ate_media_model #(
  parameter int DELAY = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic fail_in,
  output logic done_out,
  output logic err_out,
  output logic [8:0] addr_out
);
  logic [3:0] cnt;
  assign addr_out = 9'h005;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 4'h0;
      done_out <= 1'b0;
      err_out <= 1'b0;
    end else if (req_in && !done_out && cnt == 4'(DELAY)) begin
      cnt <= 4'h0;
      done_out <= 1'b1;
      err_out <= fail_in;
    end else begin
      // error line is meaningless outside the done pulse
      cnt <= (req_in && !done_out) ? cnt + 4'h1 : 4'h0;
      done_out <= 1'b0;
      err_out <= ~fail_in;
    end
  end
endmodule
`default_nettype wire

// [verif/ate_write_exec_tb.sv]
// self-checking bench for the task-file write command executor
`timescale 1ns/100ps
`default_nettype none
module ate_write_exec_tb;
  logic clk_in, rstn_in, wr_in, rd_in, dmack_in, udma_mode_in, udma_crc_err_in, fail, erased, done, merr;
  logic intrq_out, sleep_out, dmarq_out, media_req_out, media_noerase_out;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, dma_data_in, rdata_out, media_data_out, d;
  logic [27:0] media_lba_out;
  logic [8:0] maddr;
  logic [23:0] hot;
  logic [7:0] op;
  int err_count, total_checks, n;
  ate_write_exec u_ate_write_exec (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .intrq_out(intrq_out), .sleep_out(sleep_out),
    .dmarq_out(dmarq_out), .dmack_in(dmack_in), .dma_data_in(dma_data_in), .udma_mode_in(udma_mode_in),
    .udma_crc_err_in(udma_crc_err_in), .media_req_out(media_req_out), .media_lba_out(media_lba_out),
    .media_noerase_out(media_noerase_out), .media_done_in(done), .media_err_in(merr),
    .media_erased_in(erased), .media_hot_in(hot), .media_addr_in(maddr), .media_data_out(media_data_out));
  ate_media_model u_ate_media_model (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(media_req_out),
    .fail_in(fail), .done_out(done), .err_out(merr), .addr_out(maddr));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic setup(input logic [7:0] dh, input logic [7:0] sc, input logic [7:0] cnt);
    wr(ate_pkg::REG_DH, dh);
    wr(ate_pkg::REG_CYL_HI, 8'h02);
    wr(ate_pkg::REG_CYL_LO, 8'h03);
    wr(ate_pkg::REG_SEC, sc);
    wr(ate_pkg::REG_CNT, cnt);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    // let the command edge settle so a stale interrupt is not taken
    #1;
    while (intrq_out !== 1'b1) begin
      @(posedge clk_in) #1;
      k++;
      if (k > 3000) begin
        err_count++;
        finish_test();
      end
    end
  endtask
  task automatic wait_drq;
    int k;
    k = 0;
    d = 8'h00;
    while (d[ate_pkg::ST_DRQ] !== 1'b1) begin
      rd(ate_pkg::REG_CMD);
      k++;
      if (k > 50) begin
        err_count++;
        finish_test();
      end
    end
  endtask
  task automatic send_sector(input logic [7:0] k);
    for (int i = 0; i < 512; i++) wr(ate_pkg::REG_DATA, 8'(i) ^ k);
    repeat (2) @(posedge clk_in) #1;
    chk("media_data", 8'h05 ^ k, media_data_out);
  endtask
  function automatic logic [7:0] tbyte(input int i, input logic e, input logic [23:0] h);
    case (i)
      0, 4: return 8'h02;
      1, 5: return 8'h03;
      2: return 8'h01;
      3, 6: return 8'hFE;
      19: return e ? 8'hFF : 8'h00;
      24: return h[23:16];
      25: return h[15:8];
      26: return h[7:0];
      default: return 8'h00;
    endcase
  endfunction
  initial begin
    {rstn_in, wr_in, rd_in, dmack_in, udma_mode_in, udma_crc_err_in, fail, erased} = 8'h00;
    {addr_in, wdata_in, dma_data_in, hot} = '0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(ate_pkg::REG_CMD, i ? ate_pkg::OP_STBY_B : ate_pkg::OP_STBY_A);
      repeat (2) @(posedge clk_in) #1;
      chk("sleep", 1, sleep_out);
      chk("intrq", 1, intrq_out);
      rd(ate_pkg::REG_CMD);
      chk("status", 8'h50, d);
    end
    // unknown opcode, also wakes from sleep
    wr(ate_pkg::REG_CMD, 8'h00);
    wait_irq;
    chk("sleep", 0, sleep_out);
    rd(ate_pkg::REG_ERR);
    chk("error", 8'h04, d);
    // multiple write refused until enabled, block size above one refused
    for (int i = 0; i < 3; i++) begin
      if (i > 0) wr(ate_pkg::REG_CNT, 8'h02);
      wr(ate_pkg::REG_CMD, i ? ate_pkg::OP_SET_MULT : ate_pkg::OP_WR_MULT);
      wait_irq;
      rd(ate_pkg::REG_ERR);
      chk("error", 8'h04, d);
    end
    wr(ate_pkg::REG_CNT, 8'h01);
    wr(ate_pkg::REG_CMD, ate_pkg::OP_SET_MULT);
    wait_irq;
    rd(ate_pkg::REG_CMD);
    chk("status", 8'h50, d);
    erased = 1'b1;
    for (int i = 0; i < 2; i++) begin
      setup(8'hE0, 8'h10, 8'h01);
      wr(ate_pkg::REG_CMD, i ? ate_pkg::OP_WR_MULT : ate_pkg::OP_WR_MULT_NE);
      wait_drq;
      send_sector(8'h3C);
      wait_irq;
      chk("noerase", !i, media_noerase_out);
      rd(ate_pkg::REG_CMD);
      chk("status", 8'h50, d);
    end
    // two LBA sectors, low address byte FE then FF, no carry
    setup(8'hE1, 8'hFE, 8'h02);
    wr(ate_pkg::REG_CMD, ate_pkg::OP_WR_SEC_A);
    wait_drq;
    chk("intrq", 0, intrq_out);
    send_sector(8'h00);
    wait_irq;
    chk("lba", 28'h10203FE, media_lba_out);
    rd(ate_pkg::REG_CMD);
    chk("status", 8'h58, d);
    send_sector(8'h01);
    wait_irq;
    chk("lba", 28'h10203FF, media_lba_out);
    rd(ate_pkg::REG_CNT);
    chk("count", 8'h00, d);
    rd(ate_pkg::REG_SEC);
    chk("sector", 8'hFF, d);
    // program failure on the first of three sectors
    fail = 1'b1;
    for (int i = 0; i < 2; i++) begin
      setup(8'hE1, 8'hFE, 8'h03);
      wr(ate_pkg::REG_CMD, i ? ate_pkg::OP_WR_MULT : ate_pkg::OP_WR_SEC_B);
      wait_drq;
      send_sector(8'h5A);
      wait_irq;
      rd(ate_pkg::REG_CMD);
      chk("status", 8'h51, d);
      rd(ate_pkg::REG_CNT);
      chk("count", 8'h03, d);
      rd(ate_pkg::REG_SEC);
      chk("sector", 8'hFE, d);
    end
    fail = 1'b0;
    // DMA writes, the second with a transfer CRC error
    udma_mode_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      setup(8'hE0, 8'h05, 8'h01);
      udma_crc_err_in <= 1'(i);
      wr(ate_pkg::REG_CMD, i ? ate_pkg::OP_WR_DMA_B : ate_pkg::OP_WR_DMA_A);
      @(posedge clk_in);
      dmack_in <= 1'b1;
      dma_data_in <= 8'hA5;
      n = 0;
      do begin
        @(posedge clk_in) #1;
        n++;
        chk("intrq", 0, intrq_out);
      end while (dmarq_out === 1'b1 && n < 700);
      chk("dma_bytes", 512, n);
      @(posedge clk_in);
      dmack_in <= 1'b0;
      udma_crc_err_in <= 1'b0;
      wait_irq;
      rd(ate_pkg::REG_ERR);
      chk("error", i ? 8'h84 : 8'h00, d);
      rd(ate_pkg::REG_SEC);
      chk("sector", 8'h05, d);
    end
    // buffer write: sector buffer overwritten, no media program
    wr(ate_pkg::REG_CMD, ate_pkg::OP_WR_BUF);
    wait_drq;
    for (int i = 0; i < 512; i++) wr(ate_pkg::REG_DATA, 8'(i) ^ 8'h66);
    wait_irq;
    chk("media_req", 0, media_req_out);
    rd(ate_pkg::REG_CMD);
    chk("status", 8'h50, d);
    chk("media_data", 8'h66, media_data_out);
    // translate, erased with a count and then not erased without
    for (int j = 0; j < 2; j++) begin
      erased = !j;
      hot = j ? 24'h000000 : 24'h0A0B0C;
      setup(8'hE1, 8'hFE, 8'h01);
      wr(ate_pkg::REG_CMD, ate_pkg::OP_TRANSLATE);
      wait_irq;
      rd(ate_pkg::REG_CMD);
      chk("status", 8'h58, d);
      for (int i = 0; i < 512; i++) begin
        rd(ate_pkg::REG_DATA);
        chk("tbuf", tbyte(i, !j, hot), d);
      end
      wait_irq;
      rd(ate_pkg::REG_CMD);
      chk("status", 8'h50, d);
    end
    // zero count means 256 sectors: 255 left after the first
    setup(8'hE1, 8'h10, 8'h00);
    wr(ate_pkg::REG_CMD, ate_pkg::OP_WR_SEC_A);
    wait_drq;
    send_sector(8'h11);
    wait_irq;
    rd(ate_pkg::REG_CNT);
    chk("count", 8'hFF, d);
    // mid-run reset leaves the long write and disables multiple mode
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    wr(ate_pkg::REG_CMD, ate_pkg::OP_WR_MULT);
    wait_irq;
    rd(ate_pkg::REG_ERR);
    chk("error", 8'h04, d);
    finish_test();
  end
endmodule
`default_nettype wire
